// [rtl/sfr_dev.sv]
// Flash end: decodes multi-line read commands and streams array data
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_regs.svh"
module sfr_dev #(
	parameter int MEM_AW = 10
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	sfr_if.dev bus,
	input wire logic i_qpi_mode,
	input wire logic i_four_byte_addr_mode,
	input wire logic i_write_in_progress,
	input wire logic i_quad_enable,
	input wire logic i_dtr_mode,
	input wire logic i_hold_is_reset,
	input wire logic i_cfg_we,
	input wire logic [1:0] i_cfg_sel,
	input wire logic [3:0] i_cfg_dummy,
	input wire logic i_mem_we,
	input wire logic [MEM_AW-1:0] i_mem_addr,
	input wire logic [7:0] i_mem_wdata,
	output logic o_busy,
	output logic o_continuous_read_mode
);
	initial
	begin
		if (MEM_AW < 1 || MEM_AW > 32)
			$error("MEM_AW out of range");
	end

	logic [7:0] mem [2**MEM_AW];
	logic [6:0] s1_q, s2_q, s3_q;
	logic [3:0] dum_qpi_q, dum_dio_q, dum_dout_q, dum;
	logic hold_q, hold_ok, cs_n, rise, fall, rise_a, fall_a;
	sfr_pkg::sfr_dst_t st_q;
	sfr_pkg::sfr_kind_t kind_q, nk;
	logic a4_q, na4, ok, crm_q;
	logic [5:0] cnt_q, aclk;
	logic [31:0] sh_q, sh_d;
	logic [7:0] mode_q, dsr_q, byt;
	logic [MEM_AW-1:0] addr_q;
	logic [2:0] nib_q;
	logic [3:0] o_q, oe_q;

	// Pins come from the host's clock world on paper: two stages first
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			s1_q <= 7'h5f; // Idle pin levels, so no false clock edge follows reset
			s2_q <= 7'h5f;
			s3_q <= 7'h5f;
		end
		else
		begin
			s1_q <= {bus.cs_n, bus.sck, bus.hold_n, bus.io};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign cs_n = s2_q[6];
	assign rise = s2_q[5] & ~s3_q[5];
	assign fall = ~s2_q[5] & s3_q[5];
	assign hold_ok = ~i_quad_enable & ~i_dtr_mode & ~i_hold_is_reset;
	assign rise_a = rise & ~hold_q & ~cs_n;
	assign fall_a = fall & ~hold_q & ~cs_n;

	// Hold state follows hold_n only while the serial clock is low; deselect or a disabled pause clears it at any time
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			hold_q <= 1'b0;
		else if (cs_n || !hold_ok)
			hold_q <= 1'b0;
		else if (!s2_q[5])
			hold_q <= ~s2_q[4];
	end

	// Dummy counts, documented defaults after reset
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			dum_qpi_q <= `SFR_DUMMY_QPI_RST;
			dum_dio_q <= `SFR_DUMMY_DIO_RST;
			dum_dout_q <= `SFR_DUMMY_DOUT_RST;
		end
		else if (i_cfg_we)
		begin
			if (i_cfg_sel == `SFR_CFG_SEL_QPI)
				dum_qpi_q <= i_cfg_dummy;
			if (i_cfg_sel == `SFR_CFG_SEL_DIO)
				dum_dio_q <= i_cfg_dummy;
			if (i_cfg_sel == `SFR_CFG_SEL_DOUT)
				dum_dout_q <= i_cfg_dummy;
		end
	end

	// Backdoor array load from the user side
	always_ff @(posedge i_clk)
	begin
		if (i_mem_we)
			mem[i_mem_addr] <= i_mem_wdata;
	end

	// Lane width of the current phase, input shift and address length
	always_comb
	begin
		sh_d = {sh_q[30:0], s2_q[0]};
		if ((st_q == sfr_pkg::SFR_D_CMD && i_qpi_mode) || (st_q == sfr_pkg::SFR_D_ADDR
			&& kind_q == sfr_pkg::SFR_RK_QPI))
			sh_d = {sh_q[27:0], s2_q[3:0]};
		else if (st_q == sfr_pkg::SFR_D_ADDR && kind_q == sfr_pkg::SFR_RK_DIO)
			sh_d = {sh_q[29:0], s2_q[1:0]};
		unique case (kind_q)
			sfr_pkg::SFR_RK_QPI: aclk = a4_q ? 6'd8 : 6'd6;
			sfr_pkg::SFR_RK_DIO: aclk = a4_q ? 6'd16 : 6'd12;
			sfr_pkg::SFR_RK_DOUT: aclk = a4_q ? 6'd32 : 6'd24;
		endcase
		unique case (kind_q)
			sfr_pkg::SFR_RK_QPI: dum = dum_qpi_q;
			sfr_pkg::SFR_RK_DIO: dum = dum_dio_q;
			sfr_pkg::SFR_RK_DOUT: dum = dum_dout_q;
		endcase
	end

	// Opcode decode; QPI and single-line sets are kept apart
	always_comb
	begin
		nk = sfr_pkg::SFR_RK_QPI;
		na4 = i_four_byte_addr_mode;
		ok = 1'b1;
		if (i_qpi_mode)
		begin
			unique case (sh_d[7:0])
				`SFR_OP_FAST_READ, `SFR_OP_QUAD_IO_READ: na4 = i_four_byte_addr_mode;
				`SFR_OP_FAST_READ_4B: na4 = 1'b1;
				`SFR_OP_UNIQUE_ID_READ, `SFR_OP_PARAM_TABLE_READ, `SFR_OP_INFO_ROW_READ: na4 = 1'b0;
				default: ok = 1'b0;
			endcase
		end
		else
		begin
			unique case (sh_d[7:0])
				`SFR_OP_DUAL_IO_READ: nk = sfr_pkg::SFR_RK_DIO;
				`SFR_OP_DUAL_IO_READ_4B:
				begin
					nk = sfr_pkg::SFR_RK_DIO;
					na4 = 1'b1;
				end
				`SFR_OP_DUAL_OUT_READ: nk = sfr_pkg::SFR_RK_DOUT;
				`SFR_OP_DUAL_OUT_READ_4B:
				begin
					nk = sfr_pkg::SFR_RK_DOUT;
					na4 = 1'b1;
				end
				default: ok = 1'b0;
			endcase
		end
	end

	// Command sequencer; all timing taken from serial clock edges
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st_q <= sfr_pkg::SFR_D_IDLE;
			kind_q <= sfr_pkg::SFR_RK_QPI;
			a4_q <= 1'b0;
			crm_q <= 1'b0;
			cnt_q <= 6'h00;
			sh_q <= 32'h0000_0000;
			mode_q <= 8'h00;
			addr_q <= '0;
		end
		else if (cs_n)
			st_q <= sfr_pkg::SFR_D_IDLE;
		else
		begin
			unique case (st_q)
				sfr_pkg::SFR_D_IDLE:
				begin
					cnt_q <= 6'h00;
					if (crm_q)
					begin
						// Mode-byte shortcut: straight into address, command mode untouched
						kind_q <= sfr_pkg::SFR_RK_DIO;
						st_q <= i_write_in_progress ? sfr_pkg::SFR_D_IGN : sfr_pkg::SFR_D_ADDR;
					end
					else
						st_q <= sfr_pkg::SFR_D_CMD;
				end
				sfr_pkg::SFR_D_CMD:
					if (rise_a)
					begin
						sh_q <= sh_d;
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q == (i_qpi_mode ? `SFR_QPI_CMD_CLOCKS : `SFR_SPI_CMD_CLOCKS) - 6'h01)
						begin
							cnt_q <= 6'h00;
							kind_q <= nk;
							a4_q <= na4;
							st_q <= (!ok || i_write_in_progress) ? sfr_pkg::SFR_D_IGN : sfr_pkg::SFR_D_ADDR;
						end
					end
				sfr_pkg::SFR_D_ADDR:
					if (rise_a)
					begin
						sh_q <= sh_d;
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q == aclk - 6'h01)
						begin
							cnt_q <= 6'h00;
							addr_q <= sh_d[MEM_AW-1:0];
							st_q <= (dum == 4'h0) ? sfr_pkg::SFR_D_DATA : sfr_pkg::SFR_D_DUM;
						end
					end
				sfr_pkg::SFR_D_DUM:
					if (rise_a)
					begin
						cnt_q <= cnt_q + 6'h01;
						if (kind_q == sfr_pkg::SFR_RK_DIO && cnt_q < `SFR_MODE_CLOCKS)
						begin
							mode_q <= {mode_q[5:0], s2_q[1:0]};
							if (cnt_q == `SFR_MODE_CLOCKS - 6'h01)
								crm_q <= (mode_q[5:2] == `SFR_MODE_CRM_NIB);
						end
						if (cnt_q == {2'b00, dum} - 6'h01)
							st_q <= sfr_pkg::SFR_D_DATA;
					end
				sfr_pkg::SFR_D_DATA:
					if (fall_a && nib_q == 3'h0)
						addr_q <= addr_q + 1'b1;
				sfr_pkg::SFR_D_IGN: st_q <= sfr_pkg::SFR_D_IGN;
			endcase
		end
	end

	// Output shifter: new bits after each falling clock edge
	always_comb
	begin
		byt = (nib_q == 3'h0) ? mem[addr_q] : dsr_q;
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			nib_q <= 3'h0;
			dsr_q <= 8'h00;
			o_q <= 4'h0;
			oe_q <= 4'h0;
		end
		else if (st_q != sfr_pkg::SFR_D_DATA || cs_n)
		begin
			nib_q <= 3'h0;
			oe_q <= 4'h0;
		end
		else if (fall_a)
		begin
			if (kind_q == sfr_pkg::SFR_RK_QPI)
			begin
				o_q <= byt[7:4];
				dsr_q <= {byt[3:0], 4'h0};
				oe_q <= 4'hf;
				nib_q <= (nib_q == 3'h0) ? 3'h1 : nib_q - 3'h1;
			end
			else
			begin
				o_q <= {2'b00, byt[7:6]};
				dsr_q <= {byt[5:0], 2'b00};
				oe_q <= 4'h3;
				nib_q <= (nib_q == 3'h0) ? 3'h3 : nib_q - 3'h1;
			end
		end
	end

	// Hold releases the lines at once without losing the shifter
	assign bus.d_o = o_q;
	assign bus.d_oe = oe_q & {4{~hold_q & ~cs_n}};
	assign o_busy = (st_q != sfr_pkg::SFR_D_IDLE);
	assign o_continuous_read_mode = crm_q;
endmodule : sfr_dev
`default_nettype wire

// [rtl/sfr_host.sv]
// Host end: makes the serial clock and runs one read per start pulse
`timescale 1ns/1ps
`default_nettype none
`include "sfr_regs.svh"
module sfr_host #(
	parameter int HALF = `SFR_HALF_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	sfr_if.host bus,
	input wire logic i_start,
	input wire logic [7:0] i_cmd,
	input wire logic [31:0] i_addr,
	input wire logic i_qpi,
	input wire logic i_a4,
	input wire logic i_skip_cmd,
	input wire logic [7:0] i_mode,
	input wire logic [3:0] i_dummy,
	input wire logic [15:0] i_nbytes,
	input wire logic i_pause,
	output logic o_busy,
	output logic [7:0] o_rdata,
	output logic o_rvalid
);
	initial
	begin
		if (HALF < 6 || HALF > 255)
			$error("HALF must cover the device pin latency");
	end

	sfr_pkg::sfr_hst_t st_q;
	logic [7:0] div_q, k_q, c_end_q, a_end_q, m_end_q, d_end_q;
	logic [47:0] tx_q;
	logic [7:0] rx_q, rx_d;
	logic [3:0] rxn_q, o_d, oe_d;
	logic [15:0] left_q;
	logic qpi_q, dio_q, lowrel_q, done_q, sck_q, cs_n_q, hold_n_q;
	logic [3:0] o_q, oe_q;
	logic [2:0] wk;
	logic dio;
	logic [5:0] ac;

	assign dio = i_skip_cmd || (!i_qpi && (i_cmd == `SFR_OP_DUAL_IO_READ || i_cmd == `SFR_OP_DUAL_IO_READ_4B));
	// Address clocks per lane width and length
	always_comb
	begin
		if (i_qpi)
			ac = i_a4 ? 6'd8 : 6'd6;
		else if (dio)
			ac = i_a4 ? 6'd16 : 6'd12;
		else
			ac = i_a4 ? 6'd32 : 6'd24;
	end

	// Per-clock drive pattern from the segment boundaries
	always_comb
	begin
		wk = 3'd0;
		oe_d = 4'h0;
		if (k_q < c_end_q)
			wk = qpi_q ? 3'd4 : 3'd1;
		else if (k_q < a_end_q)
			wk = qpi_q ? 3'd4 : (dio_q ? 3'd2 : 3'd1);
		else if (k_q < m_end_q)
			wk = 3'd2;
		unique case (wk)
			3'd4: o_d = tx_q[47:44];
			3'd2: o_d = {2'b00, tx_q[47:46]};
			default: o_d = {3'b000, tx_q[47]};
		endcase
		if (wk == 3'd4)
			oe_d = 4'hf;
		else if (wk == 3'd2)
			oe_d = (lowrel_q && k_q >= m_end_q - 8'd2) ? 4'h0 : 4'h3;
		else if (wk == 3'd1)
			oe_d = 4'h1;
		rx_d = qpi_q ? {rx_q[3:0], bus.io} : {rx_q[5:0], bus.io[1:0]};
	end

	// Clock divider and transfer sequencer
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st_q <= sfr_pkg::SFR_H_IDLE;
			div_q <= 8'h00;
			k_q <= 8'h00;
			c_end_q <= 8'h00;
			a_end_q <= 8'h00;
			m_end_q <= 8'h00;
			d_end_q <= 8'h00;
			tx_q <= 48'h0;
			rx_q <= 8'h00;
			rxn_q <= 4'h0;
			left_q <= 16'h0000;
			qpi_q <= 1'b0;
			dio_q <= 1'b0;
			lowrel_q <= 1'b0;
			done_q <= 1'b0;
			sck_q <= 1'b0;
			cs_n_q <= 1'b1;
			hold_n_q <= 1'b1;
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
		end
		else
		begin
			o_rvalid <= 1'b0;
			div_q <= div_q + 8'h01;
			unique case (st_q)
				sfr_pkg::SFR_H_IDLE:
					if (i_start)
					begin
						qpi_q <= i_qpi;
						dio_q <= dio;
						lowrel_q <= dio && (i_dummy <= 4'h4);
						c_end_q <= i_skip_cmd ? 8'h00 : {2'b00, (i_qpi ? `SFR_QPI_CMD_CLOCKS : `SFR_SPI_CMD_CLOCKS)};
						a_end_q <= (i_skip_cmd ? 8'h00 : {2'b00, (i_qpi ? `SFR_QPI_CMD_CLOCKS
							: `SFR_SPI_CMD_CLOCKS)}) + {2'b00, ac};
						m_end_q <= (i_skip_cmd ? 8'h00 : {2'b00, (i_qpi ? `SFR_QPI_CMD_CLOCKS
							: `SFR_SPI_CMD_CLOCKS)}) + {2'b00, ac} + (dio ? {2'b00, `SFR_MODE_CLOCKS} : 8'h00);
						d_end_q <= (i_skip_cmd ? 8'h00 : {2'b00, (i_qpi ? `SFR_QPI_CMD_CLOCKS
							: `SFR_SPI_CMD_CLOCKS)}) + {2'b00, ac} + {4'h0, i_dummy};
						// Mode byte must follow the last address bit in either address width
						tx_q <= i_skip_cmd ? (i_a4 ? {i_addr, i_mode, 8'h00} : {i_addr[23:0], i_mode, 16'h0000})
							: (i_a4 ? {i_cmd, i_addr, i_mode} : {i_cmd, i_addr[23:0], i_mode, 8'h00});
						left_q <= (i_nbytes == 16'h0000) ? 16'h0001 : i_nbytes;
						k_q <= 8'h00;
						rxn_q <= 4'h0;
						done_q <= 1'b0;
						div_q <= 8'h00;
						cs_n_q <= 1'b0;
						st_q <= sfr_pkg::SFR_H_LOW;
					end
				sfr_pkg::SFR_H_LOW:
					if (div_q == 8'(HALF - 1))
					begin
						div_q <= 8'h00;
						if (i_pause || !hold_n_q)
							hold_n_q <= ~i_pause;
						else
						begin
							sck_q <= 1'b1;
							st_q <= sfr_pkg::SFR_H_HIGH;
							tx_q <= tx_q << wk;
							if (k_q >= d_end_q)
							begin
								rx_q <= rx_d;
								rxn_q <= rxn_q + (qpi_q ? 4'h4 : 4'h2);
								if (rxn_q + (qpi_q ? 4'h4 : 4'h2) == 4'h8)
								begin
									rxn_q <= 4'h0;
									o_rdata <= rx_d;
									o_rvalid <= 1'b1;
									left_q <= left_q - 16'h0001;
									done_q <= (left_q == 16'h0001);
								end
							end
						end
					end
				sfr_pkg::SFR_H_HIGH:
					if (div_q == 8'(HALF - 1))
					begin
						div_q <= 8'h00;
						sck_q <= 1'b0;
						k_q <= (k_q == 8'hff) ? k_q : k_q + 8'h01;
						st_q <= done_q ? sfr_pkg::SFR_H_END : sfr_pkg::SFR_H_LOW;
					end
				sfr_pkg::SFR_H_END:
					if (div_q == 8'(HALF - 1))
					begin
						div_q <= 8'h00;
						cs_n_q <= 1'b1;
						st_q <= sfr_pkg::SFR_H_IDLE;
					end
			endcase
		end
	end

	// Lines registered one cycle after each clock step
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_q <= 4'h0;
			oe_q <= 4'h0;
		end
		else
		begin
			o_q <= o_d;
			oe_q <= (st_q == sfr_pkg::SFR_H_LOW || st_q == sfr_pkg::SFR_H_HIGH) ? oe_d : 4'h0;
		end
	end

	assign bus.cs_n = cs_n_q;
	assign bus.sck = sck_q;
	assign bus.hold_n = hold_n_q;
	assign bus.h_o = o_q;
	assign bus.h_oe = oe_q;
	assign o_busy = (st_q != sfr_pkg::SFR_H_IDLE);
endmodule : sfr_host
`default_nettype wire

// [rtl/sfr_if.sv]
// Pin bundle between host controller and flash read front end
`timescale 1ns/1ps
`default_nettype none
interface sfr_if;
	logic cs_n;
	logic sck;
	logic hold_n;
	logic [3:0] h_o;
	logic [3:0] h_oe;
	logic [3:0] d_o;
	logic [3:0] d_oe;
	logic [3:0] io;
	// Wire level: device wins, then host, else weak pull-up
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			io[i] = d_oe[i] ? d_o[i] : (h_oe[i] ? h_o[i] : 1'b1);
	end
	modport host (output cs_n, output sck, output hold_n, output h_o, output h_oe, input io);
	modport dev (input cs_n, input sck, input hold_n, input io, output d_o, output d_oe);
endinterface : sfr_if
`default_nettype wire

// [rtl/sfr_pkg.sv]
// Types shared by both ends of the read link
package sfr_pkg;
	typedef enum logic [1:0] {SFR_RK_QPI, SFR_RK_DIO, SFR_RK_DOUT} sfr_kind_t;
	typedef enum logic [2:0] {SFR_D_IDLE, SFR_D_CMD, SFR_D_ADDR, SFR_D_DUM, SFR_D_DATA, SFR_D_IGN} sfr_dst_t;
	typedef enum logic [1:0] {SFR_H_IDLE, SFR_H_LOW, SFR_H_HIGH, SFR_H_END} sfr_hst_t;
endpackage : sfr_pkg

// [rtl/sfr_regs.svh]
// Constants of the serial flash multi-line read front end
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH
`define SFR_OP_FAST_READ 8'h0b
`define SFR_OP_FAST_READ_4B 8'h0c
`define SFR_OP_QUAD_IO_READ 8'heb
`define SFR_OP_UNIQUE_ID_READ 8'h4b
`define SFR_OP_PARAM_TABLE_READ 8'h5a
`define SFR_OP_INFO_ROW_READ 8'h68
`define SFR_OP_DUAL_IO_READ 8'hbb
`define SFR_OP_DUAL_IO_READ_4B 8'hbc
`define SFR_OP_DUAL_OUT_READ 8'h3b
`define SFR_OP_DUAL_OUT_READ_4B 8'h3c
`define SFR_DUMMY_QPI_RST 4'h6
`define SFR_DUMMY_DIO_RST 4'h4
`define SFR_DUMMY_DOUT_RST 4'h8
`define SFR_MODE_CRM_NIB 4'ha
`define SFR_MODE_CLOCKS 6'h04
`define SFR_QPI_CMD_CLOCKS 6'h02
`define SFR_SPI_CMD_CLOCKS 6'h08
`define SFR_CFG_SEL_QPI 2'h0
`define SFR_CFG_SEL_DIO 2'h1
`define SFR_CFG_SEL_DOUT 2'h2
`define SFR_HALF_CYCLES 8
`endif

// [tb/sfr_checker.sv]
// Link checker for the multi-line read pins
`timescale 1ns/1ps
`default_nettype none
module sfr_checker (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic hold_n,
	input wire logic [3:0] h_o,
	input wire logic [3:0] h_oe,
	input wire logic [3:0] d_o,
	input wire logic [3:0] d_oe,
	input wire logic [3:0] io,
	input wire logic i_hold_ok
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	// Long enough for the device pin synchronisers to catch up
	sequence s_desel;
		cs_n [*6];
	endsequence
	sequence s_held;
		(!hold_n && i_hold_ok) [*6];
	endsequence
	a_cs_stops_out:
		assert property ($rose(cs_n) |-> ##[1:5] (d_oe == 4'h0)) else $error("device drives after deselect");
	a_desel_quiet:
		assert property (s_desel |-> (d_oe == 4'h0)) else $error("device drives while deselected");
	a_hold_quiet:
		assert property (s_held |-> (d_oe == 4'h0)) else $error("device drives during pause");
	a_hold_ignored:
		assert property ((!i_hold_ok && !cs_n && $fell(hold_n)) |-> ##4 (d_oe == $past(d_oe, 4)))
			else $error("device obeyed a disabled pause");
	a_lines_float:
		assert property (s_desel |-> (io == 4'hf)) else $error("lines not pulled up while deselected");
	a_pause_sck_low:
		assert property ($fell(hold_n) |-> !sck) else $error("pause entered with clock high");
	a_resume_sck_low:
		assert property ($rose(hold_n) |-> !sck) else $error("pause left with clock high");
	a_no_contend:
		assert property ((d_oe & h_oe) == 4'h0) else $error("both ends drive one line");
	a_out_on_fall:
		assert property ((!cs_n && d_oe != 4'h0 && $changed(d_o)) |-> !sck) else $error("data moved with clock high");
	a_oe_lines:
		assert property ((d_oe != 4'h0) |-> (d_oe == 4'h3 || d_oe == 4'hf)) else $error("odd set of driven lines");
	a_sck_idle:
		assert property (cs_n |-> !sck) else $error("clock runs while deselected");
endmodule : sfr_checker
`default_nettype wire

// [tb/sfr_tb.sv]
// Self-checking bench for the multi-line read link
`timescale 1ns/1ps
`default_nettype none
module sfr_tb;
	logic i_clk, i_rstn = 1'b0, i_start = 1'b0, i_qpi = 1'b0, i_a4 = 1'b0, i_skip_cmd = 1'b0, i_pause = 1'b0;
	logic i_four_byte_addr_mode = 1'b0, i_write_in_progress = 1'b0, i_quad_enable = 1'b0;
	logic i_cfg_we = 1'b0, i_mem_we = 1'b0;
	logic i_dtr_mode = 1'b0, i_hold_is_reset = 1'b0;
	logic [1:0] i_cfg_sel = 2'h0;
	logic [3:0] i_cfg_dummy = 4'h6, i_dummy = 4'h6;
	logic [7:0] i_cmd = 8'h00, i_mode = 8'h00, i_mem_wdata = 8'h00;
	logic [31:0] i_addr = 32'h0;
	logic [15:0] i_nbytes = 16'h1;
	logic [9:0] i_mem_addr = 10'h0;
	logic h_busy, d_busy, o_rvalid, o_crm;
	logic [7:0] o_rdata;
	logic [7:0] mem [0:1023];
	logic [7:0] exp_q [$];
	logic [31:0] seed = 32'hbc7a;
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	// Opcode table: QPI first, then dual I/O, then dual output
	logic [7:0] cl [13] = '{8'h0b, 8'h0b, 8'h0c, 8'heb, 8'h4b, 8'h5a, 8'h68, 8'hbb, 8'hbb, 8'hbc, 8'h3b, 8'h3b, 8'h3c};
	logic [3:0] dl [13] = '{4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h4, 4'h4, 4'h4, 4'h8, 4'h8, 4'h8};
	logic [12:0] fl = 13'h0902;
	logic [12:0] al = 13'h1204;

	sfr_if i_sfr_if ();
	sfr_dev #(.MEM_AW(10)) i_sfr_dev (.i_clk(i_clk), .i_rstn(i_rstn), .bus(i_sfr_if), .i_qpi_mode(i_qpi),
		.i_four_byte_addr_mode(i_four_byte_addr_mode), .i_write_in_progress(i_write_in_progress),
		.i_quad_enable(i_quad_enable), .i_dtr_mode(i_dtr_mode), .i_hold_is_reset(i_hold_is_reset), .i_cfg_we(i_cfg_we),
		.i_cfg_sel(i_cfg_sel), .i_cfg_dummy(i_cfg_dummy), .i_mem_we(i_mem_we), .i_mem_addr(i_mem_addr),
		.i_mem_wdata(i_mem_wdata), .o_busy(d_busy), .o_continuous_read_mode(o_crm));
	sfr_host #(.HALF(8)) i_sfr_host (.i_clk(i_clk), .i_rstn(i_rstn), .bus(i_sfr_if), .i_start(i_start),
		.i_cmd(i_cmd), .i_addr(i_addr), .i_qpi(i_qpi), .i_a4(i_a4), .i_skip_cmd(i_skip_cmd), .i_mode(i_mode),
		.i_dummy(i_dummy), .i_nbytes(i_nbytes), .i_pause(i_pause), .o_busy(h_busy), .o_rdata(o_rdata),
		.o_rvalid(o_rvalid));
	sfr_checker i_sfr_checker (.i_clk(i_clk), .i_rstn(i_rstn), .cs_n(i_sfr_if.cs_n), .sck(i_sfr_if.sck),
		.hold_n(i_sfr_if.hold_n), .h_o(i_sfr_if.h_o), .h_oe(i_sfr_if.h_oe), .d_o(i_sfr_if.d_o),
		.d_oe(i_sfr_if.d_oe), .io(i_sfr_if.io),
		.i_hold_ok(~i_quad_enable & ~i_dtr_mode & ~i_hold_is_reset));

	// Free-running bench clock, 100 ns period
	initial
	begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// Sampled on the falling edge so flops have settled; also cuts a hang short
	always @(negedge i_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			finish_test();
		end
		if (o_rvalid === 1'b1)
			chk("read byte", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, o_rdata);
	end

	task automatic cfg(input logic [1:0] s, input logic [3:0] d);
		@(posedge i_clk);
		i_cfg_we <= 1'b1;
		i_cfg_sel <= s;
		i_cfg_dummy <= d;
		@(posedge i_clk);
		i_cfg_we <= 1'b0;
	endtask : cfg

	// One read; a refused read leaves the lines pulled up, so all ones come back
	task automatic rd(input logic [7:0] c, input logic q, fb, a4, sk, input logic [7:0] m, input logic [3:0] dm,
		input logic [31:0] a, input int n, input int pz, input logic [3:0] poe);
		int w;
		@(posedge i_clk);
		i_start <= 1'b1;
		i_cmd <= c;
		i_qpi <= q;
		i_four_byte_addr_mode <= fb;
		i_a4 <= a4;
		i_skip_cmd <= sk;
		i_mode <= m;
		i_dummy <= dm;
		i_addr <= a;
		i_nbytes <= 16'(n);
		for (int k = 0; k < n; k++)
			exp_q.push_back(i_write_in_progress ? 8'hff : mem[(a + k) & 32'h3ff]);
		@(posedge i_clk);
		i_start <= 1'b0;
		w = 0;
		#1;
		while (h_busy !== 1'b0 && w < 3000)
		begin
			@(posedge i_clk);
			w++;
			i_pause <= (pz > 0) && (w > pz) && (w < pz + 140);
			#1;
			// Deep inside the pause the device lines must have settled
			if (pz > 0 && w == pz + 100)
				chk("lines driven in pause", {4'h0, poe}, {4'h0, i_sfr_if.d_oe});
		end
		chk("host idle", 8'h00, {7'h00, h_busy});
		chk("bytes left", 8'h00, 8'(exp_q.size()));
		exp_q.delete();
		$display("test %h done", c);
		repeat (4) @(posedge i_clk);
		chk("device idle", 8'h00, {7'h00, d_busy});
	endtask : rd

	// Main sequence
	initial
	begin
		logic [31:0] r;
		repeat (8) @(posedge i_clk);
		i_rstn <= 1'b1;
		// Backdoor load, mirrored in the model
		for (int i = 0; i < 1024; i++)
		begin
			@(posedge i_clk);
			r = xs();
			mem[i] = r[7:0];
			i_mem_we <= 1'b1;
			i_mem_addr <= 10'(i);
			i_mem_wdata <= r[7:0];
		end
		@(posedge i_clk);
		i_mem_we <= 1'b0;
		// Every opcode, 0b and both dual reads in both address widths, eb in three-byte only; default dummy counts
		for (int i = 0; i < 13; i++)
			rd(cl[i], i < 7, fl[i], fl[i] | al[i], 1'b0, 8'h00, dl[i], xs(), 3, 0, 4'h0);
		// Wrap past the top of the array
		rd(8'h0b, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 4'h6, 32'h3fe, 4, 0, 4'h0);
		// Pause during the address, data must still arrive intact
		rd(8'h3b, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 4'h8, xs(), 6, 120, 4'h0);
		// Pause in the data phase: lines let go only where the pause is allowed
		for (int j = 0; j < 4; j++)
		begin
			i_quad_enable <= (j == 1);
			i_dtr_mode <= (j == 2);
			i_hold_is_reset <= (j == 3);
			rd(8'h0b, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 4'h6, xs(), 12, 260, (j == 0) ? 4'h0 : 4'hf);
		end
		i_hold_is_reset <= 1'b0;
		// Continuous mode: enter, reuse without opcode, then leave
		rd(8'hbb, 1'b0, 1'b0, 1'b0, 1'b0, 8'ha5, 4'h4, xs(), 2, 0, 4'h0);
		chk("continuous flag", 8'h01, {7'h00, o_crm});
		rd(8'hbb, 1'b0, 1'b0, 1'b0, 1'b1, 8'haf, 4'h4, xs(), 2, 0, 4'h0);
		chk("continuous flag", 8'h01, {7'h00, o_crm});
		rd(8'hbb, 1'b0, 1'b0, 1'b0, 1'b1, 8'h30, 4'h4, xs(), 2, 0, 4'h0);
		chk("continuous flag", 8'h00, {7'h00, o_crm});
		// Longer dual I/O dummy through the configuration port
		cfg(2'h1, 4'h6);
		rd(8'hbb, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 4'h6, xs(), 2, 0, 4'h0);
		cfg(2'h1, 4'h4);
		// Refused while a write runs, then served again
		i_write_in_progress <= 1'b1;
		rd(8'h0b, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 4'h6, xs(), 2, 0, 4'h0);
		i_write_in_progress <= 1'b0;
		rd(8'h0b, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 4'h6, xs(), 2, 0, 4'h0);
		finish_test();
	end
endmodule : sfr_tb
`default_nettype wire
